// file: logic/charger_pkg.sv
// shared constants and types for the charger setpoint register block
package charger_pkg;
  // serial target address and register codes
  localparam logic [6:0] TARGET_ADDR = 7'h09;
  localparam logic [7:0] CODE_AMPS = 8'h14;
  localparam logic [7:0] CODE_VOLTS = 8'h15;
  localparam logic [7:0] CODE_CEIL = 8'h3F;

  // power-on values
  localparam logic [15:0] AMPS_RESET = 16'h0000;
  localparam logic [15:0] VOLTS_RESET = 16'h0000;
  localparam logic [15:0] CEIL_RESET = 16'h0080;

  // field layout
  localparam int CODE_LSB = 7;
  localparam int CODE_MSB = 12;
  localparam int VOLTS_LSB = 4;
  localparam int VOLTS_MSB = 14;

  // clamps, 1 mA per lsb for charge, 2 mA per lsb for ceiling
  localparam logic [5:0] AMPS_CODE_MAX = 6'h3F;
  localparam logic [5:0] FOLDBACK_CODE = 6'h01;
  localparam logic [15:0] CEIL_LIMIT = 16'h157E;
  localparam logic [5:0] CEIL_CODE_MAX = 6'h2B;
  localparam logic [15:0] VOLTS_MAX_MV = 16'h4B00;
  localparam logic [15:0] VOLTS_MIN_MV = 16'h0400;

  // timing
  localparam longint CLK_HZ = 40000000;
  localparam longint WRITE_WD_S = 175;
  localparam longint SCL_LOW_MS = 25;
  localparam longint WRITE_WD_CYCLES = CLK_HZ * WRITE_WD_S;
  localparam longint SCL_LOW_CYCLES = CLK_HZ * SCL_LOW_MS / 1000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } link_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic batt_low;
    logic batt_ok;
  } pins_type;

  typedef struct packed {
    logic [5:0] battery_amps_code;
    logic [5:0] adapter_amps_code;
    logic [10:0] battery_volts_code;
    logic charge_enable;
  } dac_type;
endpackage

// file: logic/charger_setpoint_regs.sv
// serial-bus setpoint registers, clamps, foldback and watchdogs of charger
`timescale 1ns/1ps
// How it works
// R1: charge target uses bits 12..7, 128mA step
// R2: charge requests above range clamp to maximum
// R3: charge target resets to zero
// R4: charge target at code 0x14, word write
// R5: charge target reads back as written
// R6: battery below 2.5V forces 128mA until 2.7V
// R7: writing zero charge target stops charging
// R8: power-up clears voltage and charge targets
// R9: host writes both targets nonzero to charge
// R10: input ceiling uses bits 12..7, 256mA step
// R11: ceiling requests above range clamp to 11.004A
// R12: ceiling below 256mA gives zero setting
// R13: ceiling resets to 256mA setting
// R14: ceiling at code 0x3F, word write, readback
// R15: no setpoint write for 175s stops charging
// R16: clock low over 25ms stops charging
// R17: only setpoint write resumes after timeout
// R18: two bytes per access, low byte first
// R19: address, code, low, high, stop; all acked
// R20: written value applies only after stop
// R21: one register per transaction, no increment
// R22: answer only address 0001001 plus direction
// R23: voltage target at code 0x15
// R24: read sends low, host ack, high, nack
// R25: watchdog restarts on setpoint write; clock-low clears high
module charger_setpoint_regs #(
  parameter logic [32:0] WD_CYCLES = 33'(charger_pkg::WRITE_WD_CYCLES),
  parameter logic [32:0] SCL_CYCLES = 33'(charger_pkg::SCL_LOW_CYCLES)
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic batt_below_2v5,
  input wire logic batt_above_2v7,
  output charger_pkg::dac_type dac,
  output logic timed_out
);
  charger_pkg::pins_type pins;
  charger_pkg::pins_type prev_r;
  charger_pkg::link_state_type state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] byte_idx_r, byte_idx_nxt;
  logic rw_r, rw_nxt;
  logic hi_sent_r, hi_sent_nxt;
  logic [7:0] sel_r, sel_nxt;
  logic [7:0] lo_r, lo_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic full_r, full_nxt;
  logic sda_oe_nxt;
  logic [15:0] amps_r, amps_nxt;
  logic [15:0] volts_r, volts_nxt;
  logic [15:0] ceil_r, ceil_nxt;
  logic [32:0] wd_cnt_r, wd_cnt_nxt;
  logic [32:0] scl_cnt_r, scl_cnt_nxt;
  logic timeout_nxt;
  logic low_batt_r, low_batt_nxt;
  charger_pkg::dac_type dac_nxt;
  logic scl_rise, scl_fall, start_cond, stop_cond, commit, setpoint_wr;
  logic [5:0] amps_code, ceil_code;
  logic [10:0] volts_code;
  logic [15:0] rd_word;

  function automatic logic [15:0] reg_read(input logic [7:0] sel,
      input logic [15:0] amps, input logic [15:0] volts,
      input logic [15:0] ceil);
    logic [15:0] val;
    val = 16'h0000;
    if (sel == charger_pkg::CODE_AMPS) begin
      val = amps; // R5
    end else if (sel == charger_pkg::CODE_VOLTS) begin
      val = volts;
    end else if (sel == charger_pkg::CODE_CEIL) begin
      val = ceil; // R14
    end
    return val;
  endfunction

  pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({scl_in, sda_in, batt_below_2v5, batt_above_2v7}),
    .sync_out(pins)
  );

  assign scl_rise = pins.scl & ~prev_r.scl;
  assign scl_fall = ~pins.scl & prev_r.scl;
  assign start_cond = pins.scl & prev_r.scl & prev_r.sda & ~pins.sda;
  assign stop_cond = pins.scl & prev_r.scl & ~prev_r.sda & pins.sda;
  // a full word is applied only at the stop that closes it
  assign commit = stop_cond & full_r; // R20
  assign setpoint_wr = commit & ((sel_r == charger_pkg::CODE_AMPS) |
      (sel_r == charger_pkg::CODE_VOLTS));
  assign rd_word = reg_read(sel_r, amps_r, volts_r, ceil_r);

  // serial target: byte engine
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    byte_idx_nxt = byte_idx_r;
    rw_nxt = rw_r;
    hi_sent_nxt = hi_sent_r;
    sel_nxt = sel_r;
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    full_nxt = full_r;
    // data pin level only moves on bus events
    sda_oe_nxt = sda_oe;
    if (start_cond) begin
      // repeated start abandons an unfinished write
      state_nxt = charger_pkg::ST_RX;
      bit_cnt_nxt = 4'h0;
      byte_idx_nxt = 3'h0;
      full_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
    end else if (stop_cond) begin
      state_nxt = charger_pkg::ST_IDLE;
      full_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        charger_pkg::ST_IDLE: begin
          sda_oe_nxt = 1'b0;
        end
        charger_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], pins.sda}; // R18
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_nxt = 4'h0;
            state_nxt = charger_pkg::ST_ACK;
            sda_oe_nxt = 1'b1; // R19
            if (byte_idx_r == 3'h0) begin
              rw_nxt = shift_r[0];
              if (shift_r[7:1] != charger_pkg::TARGET_ADDR) begin // R22
                state_nxt = charger_pkg::ST_IDLE;
                sda_oe_nxt = 1'b0;
              end
            end else if (byte_idx_r == 3'h1) begin
              sel_nxt = shift_r; // R4 R14 R23
            end else if (byte_idx_r == 3'h2) begin
              lo_nxt = shift_r; // R18
            end else if (byte_idx_r == 3'h3) begin
              hi_nxt = shift_r;
              full_nxt = 1'b1;
            end else begin
              // a fifth byte would reach the next register: refuse it
              state_nxt = charger_pkg::ST_IDLE; // R21
              sda_oe_nxt = 1'b0;
              full_nxt = 1'b0;
            end
          end
        end
        charger_pkg::ST_ACK: begin
          if (scl_fall) begin
            byte_idx_nxt = byte_idx_r + 3'h1;
            if (rw_r && byte_idx_r == 3'h0) begin
              shift_nxt = rd_word[7:0];
              hi_sent_nxt = 1'b0;
              state_nxt = charger_pkg::ST_TX; // R24
              sda_oe_nxt = ~rd_word[7];
            end else begin
              state_nxt = charger_pkg::ST_RX;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        charger_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              bit_cnt_nxt = 4'h0;
              state_nxt = charger_pkg::ST_MACK;
              sda_oe_nxt = 1'b0;
            end else begin
              bit_cnt_nxt = bit_cnt_r + 4'h1;
              shift_nxt = {shift_r[6:0], 1'b0};
              sda_oe_nxt = ~shift_r[6];
            end
          end
        end
        charger_pkg::ST_MACK: begin
          if (scl_rise) begin
            bit_cnt_nxt = {3'h0, ~pins.sda};
          end else if (scl_fall) begin
            bit_cnt_nxt = 4'h0;
            if (bit_cnt_r[0] && !hi_sent_r) begin
              shift_nxt = rd_word[15:8];
              hi_sent_nxt = 1'b1;
              state_nxt = charger_pkg::ST_TX; // R24
              sda_oe_nxt = ~rd_word[15];
            end else begin
              state_nxt = charger_pkg::ST_IDLE;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        default: begin
          state_nxt = charger_pkg::ST_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // setpoint registers, watchdogs and foldback
  always_comb begin
    amps_nxt = amps_r;
    volts_nxt = volts_r;
    ceil_nxt = ceil_r;
    if (commit) begin
      if (sel_r == charger_pkg::CODE_AMPS) begin
        amps_nxt = {hi_r, lo_r}; // R4
      end else if (sel_r == charger_pkg::CODE_VOLTS) begin
        volts_nxt = {hi_r, lo_r}; // R23
      end else if (sel_r == charger_pkg::CODE_CEIL) begin
        ceil_nxt = {hi_r, lo_r}; // R14
      end
    end
    wd_cnt_nxt = wd_cnt_r + 33'h1;
    if (setpoint_wr) begin
      wd_cnt_nxt = 33'h0; // R25
    end else if (wd_cnt_r == WD_CYCLES) begin
      wd_cnt_nxt = wd_cnt_r;
    end
    scl_cnt_nxt = scl_cnt_r + 33'h1;
    if (pins.scl) begin
      scl_cnt_nxt = 33'h0; // R25
    end else if (scl_cnt_r == SCL_CYCLES) begin
      scl_cnt_nxt = scl_cnt_r;
    end
    // a setpoint write also clears a watchdog already at its limit
    timeout_nxt = (timed_out & ~setpoint_wr) | // R17
        (wd_cnt_r == WD_CYCLES && !setpoint_wr) | // R15
        (scl_cnt_r == SCL_CYCLES); // R16
    low_batt_nxt = low_batt_r;
    if (pins.batt_low) begin
      low_batt_nxt = 1'b1; // R6
    end else if (pins.batt_ok) begin
      low_batt_nxt = 1'b0; // R6
    end
  end

  // dac codes from the stored words
  always_comb begin
    amps_code = amps_r[charger_pkg::CODE_MSB:charger_pkg::CODE_LSB]; // R1
    if (amps_r[15:13] != 3'h0) begin
      amps_code = charger_pkg::AMPS_CODE_MAX; // R2
    end
    ceil_code = ceil_r[charger_pkg::CODE_MSB:charger_pkg::CODE_LSB]; // R10 R12
    if (ceil_r > charger_pkg::CEIL_LIMIT) begin
      ceil_code = charger_pkg::CEIL_CODE_MAX; // R11
    end
    volts_code = volts_r[charger_pkg::VOLTS_MSB:charger_pkg::VOLTS_LSB];
    if (volts_r > charger_pkg::VOLTS_MAX_MV) begin
      volts_code = charger_pkg::VOLTS_MAX_MV[charger_pkg::VOLTS_MSB:
          charger_pkg::VOLTS_LSB];
    end else if (volts_r < charger_pkg::VOLTS_MIN_MV) begin
      volts_code = 11'h000;
    end
    // both targets must be nonzero before any current flows
    dac_nxt.charge_enable = (volts_code != 11'h000) &&
        (amps_code != 6'h00) && !timeout_nxt; // R7 R8 R9
    dac_nxt.battery_amps_code = 6'h00;
    if (dac_nxt.charge_enable) begin
      dac_nxt.battery_amps_code = low_batt_nxt ?
          charger_pkg::FOLDBACK_CODE : amps_code; // R6
    end
    dac_nxt.adapter_amps_code = ceil_code;
    dac_nxt.battery_volts_code = volts_code;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prev_r <= '0;
      state_r <= charger_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      byte_idx_r <= 3'h0;
      rw_r <= 1'b0;
      hi_sent_r <= 1'b0;
      sel_r <= 8'h00;
      lo_r <= 8'h00;
      hi_r <= 8'h00;
      full_r <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      amps_r <= charger_pkg::AMPS_RESET; // R3 R8
      volts_r <= charger_pkg::VOLTS_RESET; // R8
      ceil_r <= charger_pkg::CEIL_RESET; // R13
      wd_cnt_r <= 33'h0;
      scl_cnt_r <= 33'h0;
      timed_out <= 1'b0;
      low_batt_r <= 1'b0;
      dac <= '0;
    end else begin
      prev_r <= pins;
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      byte_idx_r <= byte_idx_nxt;
      rw_r <= rw_nxt;
      hi_sent_r <= hi_sent_nxt;
      sel_r <= sel_nxt;
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      full_r <= full_nxt;
      sda_oe <= sda_oe_nxt;
      sda_out <= 1'b0;
      amps_r <= amps_nxt;
      volts_r <= volts_nxt;
      ceil_r <= ceil_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      scl_cnt_r <= scl_cnt_nxt;
      timed_out <= timeout_nxt;
      low_batt_r <= low_batt_nxt;
      dac <= dac_nxt;
    end
  end

endmodule

// file: logic/pin_sync.sv
// two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage1_nxt;
  logic [WIDTH-1:0] sync_nxt;

  // only the second stage reads the first
  always_comb begin
    stage1_nxt = async_in;
    sync_nxt = stage1_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stage1_r <= '0;
      sync_out <= '0;
    end else begin
      stage1_r <= stage1_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule

// file: verif/charger_setpoint_props.sv
// port-level assertions for the charger setpoint register block
`timescale 1ns/1ps
module charger_setpoint_props #(
  parameter logic [32:0] SCL_CYCLES = 33'd500
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic batt_below_2v5,
  input wire charger_pkg::dac_type dac,
  input wire logic timed_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // raw clock-low run length, ahead of the block's own synchroniser
  logic [32:0] low_cnt_r;
  logic [32:0] low_cnt_nxt;
  always_comb begin
    low_cnt_nxt = scl_in ? 33'h0 : low_cnt_r + 33'h1;
    if (!resetn) begin
      low_cnt_nxt = 33'h0;
    end
  end
  always_ff @(posedge ref_clk) begin
    low_cnt_r <= low_cnt_nxt;
  end
  property p_drain; sda_oe |-> sda_out == 1'b0; endproperty
  a_drain: assert property (p_drain)
    else $error("data pin driven high");
  property p_low_phase; $changed(sda_oe) |-> !scl_in; endproperty
  a_low_phase: assert property (p_low_phase)
    else $error("data changed while clock high");
  property p_enable; dac.charge_enable |->
    dac.battery_volts_code != 11'h0 && dac.battery_amps_code != 6'h00;
  endproperty
  a_enable: assert property (p_enable)
    else $error("charging with a zero target");
  property p_stop; timed_out ##1 timed_out |-> !dac.charge_enable; endproperty
  a_stop: assert property (p_stop)
    else $error("charging after timeout");
  property p_ceil; dac.adapter_amps_code <= 6'h2B; endproperty
  a_ceil: assert property (p_ceil)
    else $error("ceiling code above top");
  property p_fold; batt_below_2v5 [*8] ##0 dac.charge_enable |->
    dac.battery_amps_code == 6'h01;
  endproperty
  a_fold: assert property (p_fold)
    else $error("no foldback on low battery");
  property p_scl; low_cnt_r == SCL_CYCLES + 33'd8 |-> timed_out; endproperty
  a_scl: assert property (p_scl)
    else $error("long clock low not caught");
  property p_rst; $rose(resetn) |-> dac == '0 && !timed_out && !sda_oe;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not clear at reset");
  property p_ceil_rst; $rose(resetn) |-> ##3 dac.adapter_amps_code == 6'h01;
  endproperty
  a_ceil_rst: assert property (p_ceil_rst)
    else $error("ceiling default wrong");
endmodule

bind charger_setpoint_regs charger_setpoint_props #(
  .SCL_CYCLES(SCL_CYCLES)
) props_u (
  .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .batt_below_2v5(batt_below_2v5), .dac(dac),
  .timed_out(timed_out)
);

// file: verif/charger_setpoint_regs_test.sv
// self-checking bench for the charger setpoint register block
`timescale 1ns/1ps
module charger_setpoint_regs_test;
  localparam logic [32:0] WD = 33'd20000;
  localparam logic [32:0] SCLT = 33'd500;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic below = 1'b0;
  logic above = 1'b0;
  logic scl;
  logic host_pull;
  logic sda_out;
  logic sda_oe;
  logic timed_out;
  charger_pkg::dac_type dac;
  logic [15:0] rd;
  logic [3:0] acks;
  logic [4:0] acks5;
  int error_cnt = 0;
  int n_checks = 0;
  int wait_n;
  logic [15:0] ceil_in [5] = '{16'h2000, 16'h157F, 16'h157E, 16'h0A00,
                               16'h007F};
  logic [5:0] ceil_code [5] = '{6'h2B, 6'h2B, 6'h2A, 6'h14, 6'h00};
  // pull-up: the line is low while either party pulls it
  wire logic sda_wire = !(host_pull || sda_oe);
  initial begin
    forever #12.5 ref_clk = !ref_clk;
  end
  charger_setpoint_regs #(.WD_CYCLES(WD), .SCL_CYCLES(SCLT)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .batt_below_2v5(below),
    .batt_above_2v7(above), .dac(dac), .timed_out(timed_out));
  smbus_host_model host_u (.ref_clk(ref_clk), .sda_wire(sda_wire),
    .scl(scl), .sda_pull(host_pull));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_dac(input logic [5:0] amps, input logic en);
    check({10'h0, dac.battery_amps_code}, {10'h0, amps});
    check({15'h0, dac.charge_enable}, {15'h0, en});
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] v);
    host_u.write_word(charger_pkg::TARGET_ADDR, code, v, acks);
  endtask
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    host_u.read_word(charger_pkg::TARGET_ADDR, code, rd);
    check(rd, exp);
  endtask
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_to();
    wait_n = 0;
    while (timed_out !== 1'b1 && wait_n < 30000) begin
      @(negedge ref_clk);
      wait_n++;
    end
    check({15'h0, timed_out}, 16'h0001);
    if (timed_out !== 1'b1) begin
      complete_run();
    end
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_dac(6'h00, 1'b0);
    check({10'h0, dac.adapter_amps_code}, 16'h0001);
    check({15'h0, timed_out}, 16'h0000);
    check({15'h0, sda_out}, 16'h0000);
    rd_chk(charger_pkg::CODE_AMPS, 16'h0000);
    rd_chk(charger_pkg::CODE_CEIL, 16'h0080);
    for (int i = 0; i < 5; i++) begin
      wr(charger_pkg::CODE_CEIL, ceil_in[i]);
      check({12'h0, acks}, 16'h000F);
      check({10'h0, dac.adapter_amps_code}, 16'(ceil_code[i]));
      rd_chk(charger_pkg::CODE_CEIL, ceil_in[i]);
    end
    wr(charger_pkg::CODE_VOLTS, 16'h3000);
    chk_dac(6'h00, 1'b0);
    wr(charger_pkg::CODE_AMPS, 16'h41A0);
    chk_dac(6'h3F, 1'b1);
    check({5'h0, dac.battery_volts_code}, 16'h0300);
    rd_chk(charger_pkg::CODE_AMPS, 16'h41A0);
    rd_chk(charger_pkg::CODE_VOLTS, 16'h3000);
    host_u.write_bytes(charger_pkg::TARGET_ADDR, charger_pkg::CODE_AMPS,
        24'h000280, 1, acks5);
    check({11'h0, acks5}, 16'h001C);
    rd_chk(charger_pkg::CODE_AMPS, 16'h41A0);
    chk_dac(6'h3F, 1'b1);
    host_u.write_bytes(charger_pkg::TARGET_ADDR, charger_pkg::CODE_AMPS,
        24'hC30280, 3, acks5);
    check({11'h0, acks5}, 16'h001E);
    rd_chk(charger_pkg::CODE_AMPS, 16'h41A0);
    wr(charger_pkg::CODE_AMPS, 16'h0FFF);
    chk_dac(6'h1F, 1'b1);
    below = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk_dac(6'h01, 1'b1);
    below = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk_dac(6'h01, 1'b1);
    above = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk_dac(6'h1F, 1'b1);
    rd_chk(charger_pkg::CODE_AMPS, 16'h0FFF);
    host_u.write_word(7'h0A, charger_pkg::CODE_AMPS, 16'h0000, acks);
    check({12'h0, acks}, 16'h0000);
    chk_dac(6'h1F, 1'b1);
    wr(charger_pkg::CODE_AMPS, 16'h0000);
    chk_dac(6'h00, 1'b0);
    wr(charger_pkg::CODE_AMPS, 16'h0FFF);
    wait_to();
    check({15'h0, wait_n > 19900 && wait_n < 20100}, 16'h0001);
    chk_dac(6'h00, 1'b0);
    wr(charger_pkg::CODE_AMPS, 16'h0FFF);
    check({15'h0, timed_out}, 16'h0000);
    chk_dac(6'h1F, 1'b1);
    host_u.hold_low(600);
    wait_to();
    chk_dac(6'h00, 1'b0);
    wr(charger_pkg::CODE_VOLTS, 16'h3000);
    chk_dac(6'h1F, 1'b1);
    complete_run();
  end
endmodule

// file: verif/smbus_host_model.sv
// two-wire bus host model doing word writes and word reads
`timescale 1ns/1ps
module smbus_host_model (
  input wire logic ref_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // also serves as repeated start: release, raise clock, then pull data
  task automatic start_c();
    sda_pull = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_pull = 1'b1;
    wt(8);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    wt(4);
    sda_pull = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_pull = 1'b0;
    wt(16);
  endtask
  // 200 ns bit period: data moves 2 cycles past the fall
  task automatic bit_c(input logic b, output logic r);
    wt(2);
    sda_pull = !b;
    wt(2);
    scl = 1'b1;
    wt(2);
    r = sda_wire;
    wt(2);
    scl = 1'b0;
  endtask
  task automatic byte_c(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], r);
      q[i] = r;
    end
    bit_c(last, r);
    ack = !r;
  endtask
  task automatic write_word(input logic [6:0] adr, input logic [7:0] code,
                            input logic [15:0] v, output logic [3:0] acks);
    logic [7:0] q;
    start_c();
    byte_c({adr, 1'b0}, 1'b1, q, acks[3]);
    byte_c(code, 1'b1, q, acks[2]);
    byte_c(v[7:0], 1'b1, q, acks[1]);
    byte_c(v[15:8], 1'b1, q, acks[0]);
    stop_c();
  endtask
  task automatic read_word(input logic [6:0] adr, input logic [7:0] code,
                           output logic [15:0] v);
    logic [7:0] q;
    logic a;
    start_c();
    byte_c({adr, 1'b0}, 1'b1, q, a);
    byte_c(code, 1'b1, q, a);
    stop_c();
    start_c();
    byte_c({adr, 1'b1}, 1'b1, q, a);
    byte_c(8'hFF, 1'b0, q, a);
    v[7:0] = q;
    byte_c(8'hFF, 1'b1, q, a);
    v[15:8] = q;
    stop_c();
  endtask
  // write cut short or run long: n data bytes, low byte first
  task automatic write_bytes(input logic [6:0] adr, input logic [7:0] code,
                             input logic [23:0] v, input int n,
                             output logic [4:0] acks);
    logic [7:0] q;
    logic a;
    acks = 5'h00;
    start_c();
    byte_c({adr, 1'b0}, 1'b1, q, a);
    acks[4] = a;
    byte_c(code, 1'b1, q, a);
    acks[3] = a;
    for (int i = 0; i < n; i++) begin
      byte_c(v[8*i +: 8], 1'b1, q, a);
      acks[2 - i] = a;
    end
    stop_c();
  endtask
  task automatic hold_low(input int n);
    scl = 1'b0;
    wt(n);
    scl = 1'b1;
    wt(16);
  endtask
endmodule
